// ---- rtl/ati_target.sv ----
// Purpose: Two-wire bus target port and register file of a converter.
// Assumes: link_clk oversamples SCL/SDA at least ten times the bus rate.
// Notes:   Bus engine runs on link_clk, registers on clk; toggles cross.

// Operation
// - Acknowledge general call with write bit; next byte is a command.
// - General call command 06h resets all registers and enters power-down.
// - Never acknowledge a high-speed controller code; its last three bits are ignored.
// - Controller code enables high-speed filtering; the next STOP ends it.
// - Standard and fast modes work without any activation sequence.
// - Target only; the clock line is never driven.
// - Write: address, pointer, two data bytes stored in the selected register.
// - Register words travel high byte first, then low byte.
// - Acknowledge address, pointer and every data byte of a write.
// - Read address sends high then low byte of the pointed register.
// - Controller not-acknowledge, START or STOP ends a read; data released.
// - Pointer is kept across transfers; reads use the last written pointer, or result after a general call 06h reset.
// - Address plus pointer alone updates the pointer and writes nothing.
// - Pointer low bits select result, config, low or high limit.
// - Result is 16-bit two's complement, saturating at 7FFFh and 8000h.
// - Result reads zero after reset until the first conversion loads it.
// - Bus address is one of four set by the strap code.
module ati_target #(
  parameter int SAMPLE_W = 24
) (
  // System clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Bus side, on its own clock
  input  wire logic                link_clk,
  input  wire logic                scl_in,
  input  wire logic                sda_in,
  output logic                     sda_out,
  output logic                     sda_oe,
  input  wire logic [1:0]          addr_sel,
  output logic                     hs_filter_en,
  // Converter side
  input  wire logic                conv_valid,
  input  wire logic [SAMPLE_W-1:0] conv_sample,
  output logic [15:0]              config_word,
  output logic [15:0]              low_limit,
  output logic [15:0]              high_limit,
  output logic [15:0]              result_word,
  output logic                     power_down
);

  // ==========================================================================
  // Link-domain reset and input synchronisers
  // ==========================================================================
  logic       link_rst_n;
  logic [1:0] line_s;
  logic [1:0] strap_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_q_reg;
  logic       sda_q_reg;

  ati_sync #(.W(1), .RESET_VAL(1'b0)) u_rst_sync (
    .clk   (link_clk),
    .rst_n (1'b1),
    .d     (rst_n),
    .q     (link_rst_n)
  );

  ati_sync #(.W(2), .RESET_VAL(2'h3)) u_line_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     ({scl_in, sda_in}),
    .q     (line_s)
  );

  ati_sync #(.W(2), .RESET_VAL(2'h0)) u_strap_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     (addr_sel),
    .q     (strap_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  // ==========================================================================
  // Bus event decode
  // ==========================================================================
  ati_pkg::ati_state_e state_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  bit_cnt_reg;
  logic [1:0]  byte_idx_reg;
  logic        read_reg;
  logic        gc_reg;
  logic [7:0]  tx_reg;
  logic        tx_lsb_reg;
  logic        sda_oe_reg;
  logic [15:0] rd_word_reg;
  logic [6:0]  own_addr;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic        byte_done;
  logic        addr_hit;
  logic        gc_hit;
  logic        hs_hit;
  logic        rx_done;
  logic [7:0]  next_tx;

  assign own_addr  = 7'(ati_pkg::ADDR_BASE + {5'h00, strap_s});
  assign scl_rise  = scl_s & ~scl_q_reg;
  assign scl_fall  = ~scl_s & scl_q_reg;
  assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign stop_det  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  assign byte_done = scl_fall & (bit_cnt_reg == 4'h8);
  assign addr_hit  = (state_reg == ati_pkg::ST_ADDR) & byte_done
                     & (shift_reg[7:1] == own_addr);
  assign gc_hit    = (state_reg == ati_pkg::ST_ADDR) & byte_done
                     & (shift_reg == ati_pkg::GEN_CALL_ADDR);
  assign hs_hit    = (state_reg == ati_pkg::ST_ADDR) & byte_done
                     & (shift_reg[7:3] == ati_pkg::HS_CODE_PREFIX);
  assign rx_done   = (state_reg == ati_pkg::ST_RX) & byte_done;
  assign next_tx   = tx_lsb_reg ? rd_word_reg[7:0] : rd_word_reg[15:8];

  // ==========================================================================
  // Bus engine
  // ==========================================================================
  // Standard, fast and high-speed rates share one engine; no setup.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      state_reg    <= ati_pkg::ST_IDLE;
      shift_reg    <= 8'h00;
      bit_cnt_reg  <= 4'h0;
      byte_idx_reg <= 2'h0;
      read_reg     <= 1'b0;
      gc_reg       <= 1'b0;
      tx_reg       <= 8'h00;
      tx_lsb_reg   <= 1'b0;
      sda_oe_reg   <= 1'b0;
    end else if (start_det) begin
      state_reg   <= ati_pkg::ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg  <= 1'b0;
    end else if (stop_det) begin
      state_reg  <= ati_pkg::ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ati_pkg::ST_IDLE: begin
          sda_oe_reg <= 1'b0;
        end
        ati_pkg::ST_ADDR, ati_pkg::ST_RX: begin
          if (scl_rise) begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
          end else if (byte_done) begin
            if (state_reg == ati_pkg::ST_RX) begin
              sda_oe_reg   <= 1'b1;
              state_reg    <= ati_pkg::ST_RX_ACK;
              if (byte_idx_reg != 2'h3) begin
                byte_idx_reg <= 2'(byte_idx_reg + 2'h1);
              end
            end else if (addr_hit || gc_hit) begin
              sda_oe_reg   <= 1'b1;
              state_reg    <= ati_pkg::ST_ADDR_ACK;
              read_reg     <= addr_hit & shift_reg[0];
              gc_reg       <= gc_hit;
              byte_idx_reg <= 2'h0;
            end else begin
              // Controller codes and foreign addresses stay unanswered.
              state_reg <= ati_pkg::ST_IDLE;
            end
          end
        end
        ati_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (read_reg) begin
              tx_reg     <= rd_word_reg[15:8];
              sda_oe_reg <= ~rd_word_reg[15];
              tx_lsb_reg <= 1'b1;
              state_reg  <= ati_pkg::ST_TX;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ati_pkg::ST_RX;
            end
          end
        end
        ati_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            sda_oe_reg  <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= ati_pkg::ST_RX;
          end
        end
        ati_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              sda_oe_reg <= 1'b0;
              state_reg  <= ati_pkg::ST_TX_ACK;
            end else begin
              tx_reg      <= {tx_reg[6:0], 1'b0};
              sda_oe_reg  <= ~tx_reg[6];
              bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
            end
          end
        end
        ati_pkg::ST_TX_ACK: begin
          if (scl_rise && sda_s) begin
            state_reg <= ati_pkg::ST_IDLE;
          end else if (scl_fall) begin
            tx_reg      <= next_tx;
            sda_oe_reg  <= ~next_tx[7];
            tx_lsb_reg  <= ~tx_lsb_reg;
            bit_cnt_reg <= 4'h0;
            state_reg   <= ati_pkg::ST_TX;
          end
        end
      endcase
    end
  end

  // Open drain: only a low is ever driven, and never on the clock line.
  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_reg;

  // ==========================================================================
  // Pointer, write capture and general call command
  // ==========================================================================
  logic [1:0]      ptr_reg;
  logic [7:0]      msb_reg;
  ati_pkg::ati_wr_s wr_reg;
  logic            wr_tgl_reg;
  logic            gcr_tgl_reg;
  logic            hs_mode_reg;

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      ptr_reg     <= ati_pkg::PTR_RESET;
      msb_reg     <= 8'h00;
      wr_reg      <= '0;
      wr_tgl_reg  <= 1'b0;
      gcr_tgl_reg <= 1'b0;
    end else if (rx_done && gc_reg) begin
      if (shift_reg == ati_pkg::GC_RESET_CMD) begin
        ptr_reg     <= ati_pkg::PTR_RESET;
        gcr_tgl_reg <= ~gcr_tgl_reg;
      end
    end else if (rx_done) begin
      unique case (byte_idx_reg)
        2'h0: ptr_reg <= shift_reg[1:0];
        2'h1: msb_reg <= shift_reg;
        2'h2: begin
          wr_reg.sel  <= ptr_reg;
          wr_reg.data <= {msb_reg, shift_reg};
          wr_tgl_reg  <= ~wr_tgl_reg;
        end
        2'h3: ;
      endcase
    end
  end

  // High-speed filter flag lasts from the controller code to the next STOP.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      hs_mode_reg <= 1'b0;
    end else if (stop_det) begin
      hs_mode_reg <= 1'b0;
    end else if (hs_hit) begin
      hs_mode_reg <= 1'b1;
    end
  end

  assign hs_filter_en = hs_mode_reg;

  // ==========================================================================
  // Read request handshake, link side
  // ==========================================================================
  logic rd_req_tgl_reg;
  logic rd_ack_tgl_reg;
  logic rd_ack_s;
  logic rd_ack_q_reg;
  logic [15:0] rd_data_reg;

  ati_sync #(.W(1), .RESET_VAL(1'b0)) u_ack_sync (
    .clk   (link_clk),
    .rst_n (link_rst_n),
    .d     (rd_ack_tgl_reg),
    .q     (rd_ack_s)
  );

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      rd_req_tgl_reg <= 1'b0;
      rd_ack_q_reg   <= 1'b0;
      rd_word_reg    <= 16'h0000;
    end else begin
      rd_ack_q_reg <= rd_ack_s;
      if (addr_hit && shift_reg[0]) begin
        rd_req_tgl_reg <= ~rd_req_tgl_reg;
      end
      if (rd_ack_s != rd_ack_q_reg) begin
        rd_word_reg <= rd_data_reg;
      end
    end
  end

  // ==========================================================================
  // System-domain register file
  // ==========================================================================
  logic [2:0]  tgl_s;
  logic [2:0]  tgl_q_reg;
  logic        wr_ev;
  logic        gcr_ev;
  logic        rd_ev;
  logic [15:0] clip_code;
  logic [15:0] config_reg;
  logic [15:0] low_limit_reg;
  logic [15:0] high_limit_reg;
  logic [15:0] result_reg;

  ati_sync #(.W(3), .RESET_VAL(3'h0)) u_tgl_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({wr_tgl_reg, gcr_tgl_reg, rd_req_tgl_reg}),
    .q     (tgl_s)
  );

  ati_clip #(.IN_W(SAMPLE_W)) u_clip (
    .sample (conv_sample),
    .code   (clip_code)
  );

  assign wr_ev  = tgl_s[2] ^ tgl_q_reg[2];
  assign gcr_ev = tgl_s[1] ^ tgl_q_reg[1];
  assign rd_ev  = tgl_s[0] ^ tgl_q_reg[0];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tgl_q_reg <= 3'h0;
    end else begin
      tgl_q_reg <= tgl_s;
    end
  end

  // Written registers; the result code is read-only and ignores writes.
  always_ff @(posedge clk) begin
    if (!rst_n || gcr_ev) begin
      config_reg     <= ati_pkg::CONFIG_RESET;
      low_limit_reg  <= ati_pkg::LOW_LIMIT_RESET;
      high_limit_reg <= ati_pkg::HIGH_LIMIT_RESET;
    end else if (wr_ev) begin
      unique case (wr_reg.sel)
        ati_pkg::PTR_RESULT: ;
        ati_pkg::PTR_CONFIG: config_reg     <= wr_reg.data;
        ati_pkg::PTR_LOW:    low_limit_reg  <= wr_reg.data;
        ati_pkg::PTR_HIGH:   high_limit_reg <= wr_reg.data;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || gcr_ev) begin
      result_reg <= ati_pkg::RESULT_RESET;
    end else if (conv_valid) begin
      result_reg <= clip_code;
    end
  end

  // The pointer is stable while a read request is outstanding.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_reg    <= 16'h0000;
      rd_ack_tgl_reg <= 1'b0;
    end else if (rd_ev) begin
      rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
      unique case (ptr_reg)
        ati_pkg::PTR_RESULT: rd_data_reg <= result_reg;
        ati_pkg::PTR_CONFIG: rd_data_reg <= config_reg;
        ati_pkg::PTR_LOW:    rd_data_reg <= low_limit_reg;
        ati_pkg::PTR_HIGH:   rd_data_reg <= high_limit_reg;
      endcase
    end
  end

  assign config_word = config_reg;
  assign low_limit   = low_limit_reg;
  assign high_limit  = high_limit_reg;
  assign result_word = result_reg;
  assign power_down  = config_reg[ati_pkg::CFG_MODE_BIT];

endmodule // ati_target

// ---- rtl/ati_pkg.sv ----
// Purpose: Shared constants and types of the converter two-wire target port.
// Assumes: Pointer codes select one of four 16-bit registers.
// Notes:   Every figure used by more than one file is named here once.

package ati_pkg;

  // ==========================================================================
  // Register selection codes
  // ==========================================================================
  localparam logic [1:0]  PTR_RESULT      = 2'h0;
  localparam logic [1:0]  PTR_CONFIG      = 2'h1;
  localparam logic [1:0]  PTR_LOW         = 2'h2;
  localparam logic [1:0]  PTR_HIGH        = 2'h3;
  localparam logic [1:0]  PTR_RESET       = 2'h0;

  // ==========================================================================
  // Bus codes
  // ==========================================================================
  localparam logic [6:0]  ADDR_BASE       = 7'h48;
  localparam logic [7:0]  GEN_CALL_ADDR   = 8'h00;
  localparam logic [7:0]  GC_RESET_CMD    = 8'h06;
  localparam logic [4:0]  HS_CODE_PREFIX  = 5'h01;

  // ==========================================================================
  // Reset values and fields
  // ==========================================================================
  localparam logic [15:0] RESULT_RESET    = 16'h0000;
  localparam logic [15:0] CONFIG_RESET    = 16'h8583;
  localparam logic [15:0] LOW_LIMIT_RESET = 16'h8000;
  localparam logic [15:0] HIGH_LIMIT_RESET = 16'h7fff;
  localparam int          CFG_MODE_BIT    = 8;
  localparam logic [15:0] SAT_MAX_CODE    = 16'h7fff;
  localparam logic [15:0] SAT_MIN_CODE    = 16'h8000;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic [1:0]  sel;
    logic [15:0] data;
  } ati_wr_s;

  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_ADDR     = 7'h02,
    ST_ADDR_ACK = 7'h04,
    ST_RX       = 7'h08,
    ST_RX_ACK   = 7'h10,
    ST_TX       = 7'h20,
    ST_TX_ACK   = 7'h40
  } ati_state_e;

endpackage

// ---- rtl/ati_sync.sv ----
// Purpose: Two-flop synchroniser for levels entering a clock domain.
// Assumes: Each bit is an independent level or a toggle.
// Notes:   The first stage feeds only the second stage.

module ati_sync #(
  parameter int         W         = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= RESET_VAL;
      q        <= RESET_VAL;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule // ati_sync

// ---- rtl/ati_clip.sv ----
// Purpose: Saturates a wide signed sample to a 16-bit two's-complement code.
// Assumes: IN_W is at least 17; the sample is in units of one result LSB.
// Notes:   Purely combinational; the caller registers the result.

module ati_clip #(
  parameter int IN_W = 24
) (
  // Sample in, code out
  input  wire logic [IN_W-1:0] sample,
  output logic      [15:0]     code
);

  logic pos_over;
  logic neg_over;

  // Any upper bit that differs from the sign means the code is out of range.
  assign pos_over = ~sample[IN_W-1] & (|sample[IN_W-2:15]);
  assign neg_over = sample[IN_W-1] & ~(&sample[IN_W-2:15]);

  always_comb begin
    if (pos_over) begin
      code = ati_pkg::SAT_MAX_CODE;
    end else if (neg_over) begin
      code = ati_pkg::SAT_MIN_CODE;
    end else begin
      code = sample[15:0];
    end
  end

endmodule // ati_clip

// ---- verif/ati_target_properties.sv ----
// Purpose: Concurrent checks on the ports of the two-wire target port.
// Assumes: scl_in and sda_in carry the resolved bus levels.
// Notes:   Bound to every ati_target instance at the foot of this file.

module ati_target_properties #(
  parameter int SAMPLE_W = 24
) (
  // Clocks and reset
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                link_clk,
  // Bus side
  input wire logic                scl_in,
  input wire logic                sda_in,
  input wire logic                sda_out,
  input wire logic                sda_oe,
  input wire logic [1:0]          addr_sel,
  input wire logic                hs_filter_en,
  // Converter side
  input wire logic                conv_valid,
  input wire logic [SAMPLE_W-1:0] conv_sample,
  input wire logic [15:0]         config_word,
  input wire logic [15:0]         low_limit,
  input wire logic [15:0]         high_limit,
  input wire logic [15:0]         result_word,
  input wire logic                power_down
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Bus events
  // ==========================================================================
  sequence start_seq;
    scl_in && sda_in ##1 scl_in && !sda_in;
  endsequence

  sequence stop_seq;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence

  function automatic logic [15:0] sat(input logic [SAMPLE_W-1:0] s);
    if ($signed(s) > 32767) return 16'h7fff;
    if ($signed(s) < -32768) return 16'h8000;
    return s[15:0];
  endfunction

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_RESET_VALUES:
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> result_word == ati_pkg::RESULT_RESET
        && config_word == ati_pkg::CONFIG_RESET && power_down)
    else $error("Registers not at reset values after reset");
  AST_POWER_DOWN:
    assert property (@(posedge clk) disable iff (!rst_n)
      power_down == config_word[ati_pkg::CFG_MODE_BIT])
    else $error("Power-down level differs from mode bit");
  AST_CONV_LOAD:
    assert property (@(posedge clk) disable iff (!rst_n)
      conv_valid |=> result_word == sat($past(conv_sample)))
    else $error("Result not the saturated sample");
  AST_RESULT_HOLD:
    assert property (@(posedge clk) disable iff (!rst_n)
      !conv_valid |=> $stable(result_word) || result_word == 16'h0000)
    else $error("Result changed without a conversion");
  AST_START_RELEASE:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      start_seq |-> ##[1:8] !sda_oe)
    else $error("Data line held after START");
  AST_STOP_NORMAL:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      stop_seq |-> ##[1:8] (!hs_filter_en && !sda_oe))
    else $error("High-speed filter or data drive kept after STOP");
  AST_CODE_NO_ACK:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      $rose(hs_filter_en) |-> (!sda_oe) [*8])
    else $error("Controller code acknowledged");
  AST_OE_STEADY:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      scl_in [*5] |-> $stable(sda_oe))
    else $error("Data drive changed while clock high");
  AST_OPEN_DRAIN:
    assert property (@(posedge link_clk) disable iff (!rst_n)
      sda_oe |-> !sda_out)
    else $error("Data line driven high");
endmodule // ati_target_properties

bind ati_target ati_target_properties #(.SAMPLE_W(SAMPLE_W))
  ati_target_properties_inst (.clk, .rst_n, .link_clk, .scl_in, .sda_in,
  .sda_out, .sda_oe, .addr_sel, .hs_filter_en, .conv_valid, .conv_sample,
  .config_word, .low_limit, .high_limit, .result_word, .power_down);

// ---- verif/ati_ctl_model.sv ----
// Purpose: Behavioural two-wire bus controller facing the target port.
// Assumes: The bench resolves the data wire with a pull-up.
// Notes:   Each clock phase lasts at least ten link clock periods.

module ati_ctl_model (
  // Link clock
  input wire logic link_clk,
  // Bus lines
  input wire logic sda_in,
  output logic     scl_out,
  output logic     sda_rel
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_out = 1'b1;
    sda_rel = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  task automatic put_bit(input logic b);
    sda_rel <= b;
    hold(5);
    scl_out <= 1'b1;
    hold(10);
    scl_out <= 1'b0;
    hold(5);
  endtask

  task automatic get_bit(output logic b);
    sda_rel <= 1'b1;
    hold(5);
    scl_out <= 1'b1;
    hold(5);
    b = sda_in;
    hold(5);
    scl_out <= 1'b0;
    hold(5);
  endtask

  // Works as a first or a repeated START.
  task automatic start();
    sda_rel <= 1'b1;
    hold(5);
    scl_out <= 1'b1;
    hold(5);
    sda_rel <= 1'b0;
    hold(5);
    scl_out <= 1'b0;
    hold(5);
  endtask

  task automatic stop();
    sda_rel <= 1'b0;
    hold(5);
    scl_out <= 1'b1;
    hold(5);
    sda_rel <= 1'b1;
    hold(10);
  endtask

  task automatic send(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack_n);
  endtask

  task automatic recv(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(nack);
  endtask
endmodule // ati_ctl_model

// ---- verif/test_adc_i2c_target_register_port.sv ----
// Purpose: Self-checking bench of the two-wire target port.
// Assumes: Seeded random samples and data, with fixed corner cases.
// Notes:   Register contents are tracked in a shadow array.

`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
  end

module test_adc_i2c_target_register_port;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  addr_sel = 2'h0;
  logic        conv_valid = 1'b0;
  logic [23:0] conv_sample = 24'h0;
  logic        scl_out, sda_rel, sda_out, sda_oe, hs_filter_en, power_down;
  logic [15:0] config_word, low_limit, high_limit, result_word;
  logic [15:0] shadow [4];
  logic [23:0] corner [6] = '{24'h007fff, 24'h008000, 24'hff8000,
                              24'hff7fff, 24'h800000, 24'h7fffff};
  int          err_count = 0;
  int          checks = 0;
  wire         sda_wire = sda_rel & (sda_oe ? sda_out : 1'b1);

  always #4 clk = ~clk;
  always #7.5 link_clk = ~link_clk;

  ati_target #(.SAMPLE_W(24)) ati_target_inst (.clk, .rst_n, .link_clk,
    .scl_in(scl_out), .sda_in(sda_wire), .sda_out, .sda_oe, .addr_sel,
    .hs_filter_en, .conv_valid, .conv_sample, .config_word, .low_limit,
    .high_limit, .result_word, .power_down);
  ati_ctl_model ati_ctl_model_inst (.link_clk, .sda_in(sda_wire), .scl_out,
    .sda_rel);

  function automatic logic [7:0] dev(input logic rw);
    return {ati_pkg::ADDR_BASE + {5'h0, addr_sel}, rw};
  endfunction

  function automatic logic [15:0] exp_sat(input logic [23:0] s);
    if ($signed(s) > 32767) return 16'h7fff;
    if ($signed(s) < -32768) return 16'h8000;
    return s[15:0];
  endfunction

  task automatic defaults();
    shadow = '{ati_pkg::RESULT_RESET, ati_pkg::CONFIG_RESET,
               ati_pkg::LOW_LIMIT_RESET, ati_pkg::HIGH_LIMIT_RESET};
  endtask

  task automatic chk_regs();
    `CHK("result", shadow[0], result_word)
    `CHK("config", shadow[1], config_word)
    `CHK("low", shadow[2], low_limit)
    `CHK("high", shadow[3], high_limit)
    `CHK("power down", shadow[1][8], power_down)
  endtask

  task automatic byte_out(input logic [7:0] d, input logic exp_n,
                          input string what);
    logic a;
    ati_ctl_model_inst.send(d, a);
    `CHK(what, exp_n, a)
  endtask

  task automatic wr_reg(input logic [1:0] sel, input logic [15:0] d,
                        input logic full);
    ati_ctl_model_inst.start();
    byte_out(dev(1'b0), 1'b0, "addr ack");
    byte_out({6'h0, sel}, 1'b0, "ptr ack");
    if (full) begin
      byte_out(d[15:8], 1'b0, "msb ack");
      byte_out(d[7:0], 1'b0, "lsb ack");
    end
    ati_ctl_model_inst.stop();
    repeat (10) @(posedge clk);
  endtask

  task automatic rd_reg(input logic [15:0] exp, input string what);
    logic [7:0] hi, lo;
    ati_ctl_model_inst.start();
    byte_out(dev(1'b1), 1'b0, "read addr ack");
    ati_ctl_model_inst.recv(1'b0, hi);
    ati_ctl_model_inst.recv(1'b1, lo);
    `CHK("released", 1'b0, sda_oe)
    `CHK(what, exp, {hi, lo})
    ati_ctl_model_inst.stop();
  endtask

  task automatic gcall(input logic [7:0] cmd);
    ati_ctl_model_inst.start();
    byte_out(ati_pkg::GEN_CALL_ADDR, 1'b0, "gc ack");
    byte_out(cmd, 1'b0, "gc cmd ack");
    ati_ctl_model_inst.stop();
    repeat (10) @(posedge clk);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // About 20k clock cycles of bus traffic are expected.
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    conclude();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    logic [15:0] d;
    logic [23:0] smp;
    void'($urandom(32'h0643));
    defaults();
    @(posedge clk);
    addr_sel <= 2'($urandom);
    repeat (7) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    chk_regs();
    rd_reg(shadow[0], "read result after reset");
    for (int s = 1; s < 4; s++) begin
      d = 16'($urandom);
      wr_reg(s[1:0], d, 1'b1);
      shadow[s] = d;
      chk_regs();
      rd_reg(shadow[s], "readback");
    end
    wr_reg(2'h2, 16'h0000, 1'b0);
    chk_regs();
    rd_reg(shadow[2], "pointer kept");
    rd_reg(shadow[2], "pointer kept again");
    for (int i = 0; i < 10; i++) begin
      smp = (i < 6) ? corner[i] : 24'($urandom);
      @(posedge clk);
      conv_sample <= smp;
      conv_valid <= 1'b1;
      @(posedge clk);
      conv_valid <= 1'b0;
      shadow[0] = exp_sat(smp);
      @(posedge clk);
      chk_regs();
    end
    wr_reg(2'h0, 16'($urandom), 1'b1);
    chk_regs();
    rd_reg(shadow[0], "read result");
    ati_ctl_model_inst.start();
    byte_out(dev(1'b0) ^ 8'h02, 1'b1, "foreign addr");
    ati_ctl_model_inst.stop();
    ati_ctl_model_inst.start();
    byte_out(8'h08 | 8'($urandom % 8), 1'b1, "code nack");
    `CHK("hs on", 1'b1, hs_filter_en)
    ati_ctl_model_inst.stop();
    `CHK("hs off", 1'b0, hs_filter_en)
    ati_ctl_model_inst.start();
    byte_out(ati_pkg::GEN_CALL_ADDR | 8'h01, 1'b1, "gc read");
    ati_ctl_model_inst.stop();
    d = 16'($urandom) & 16'hfeff;
    wr_reg(2'h1, d, 1'b1);
    shadow[1] = d;
    gcall(8'h04);
    chk_regs();
    gcall(ati_pkg::GC_RESET_CMD);
    defaults();
    chk_regs();
    rd_reg(shadow[0], "pointer after reset");
    ati_ctl_model_inst.start();
    byte_out(dev(1'b1), 1'b0, "short read ack");
    ati_ctl_model_inst.recv(1'b1, d[15:8]);
    `CHK("short read released", 1'b0, sda_oe)
    `CHK("short read", shadow[0][15:8], d[15:8])
    ati_ctl_model_inst.stop();
    conclude();
  end
endmodule // test_adc_i2c_target_register_port
